// File: hw/cfs_pkg.sv
package cfs_pkg;

   // Register byte offsets
   localparam logic [11:0] CFS_OFF_RXF1 = 12'h010;
   localparam logic [11:0] CFS_OFF_INTEN = 12'h014;
   localparam logic [11:0] CFS_OFF_ERRSTAT = 12'h018;

   // Reset values
   localparam logic [31:0] CFS_RST_RXF1 = 32'h0000_0000;
   localparam logic [31:0] CFS_RST_INTEN = 32'h0000_0000;

   // FIFO 1 status fields
   localparam int CFS_RXF1_CNT_LO = 0;
   localparam int CFS_RXF1_FULL = 3;
   localparam int CFS_RXF1_OVR = 4;
   localparam int CFS_RXF1_REL = 5;

   // Interrupt enable fields
   localparam int CFS_IE_TXME = 0;
   localparam int CFS_IE_F0P = 1;
   localparam int CFS_IE_F0F = 2;
   localparam int CFS_IE_F0O = 3;
   localparam int CFS_IE_F1P = 4;
   localparam int CFS_IE_F1F = 5;
   localparam int CFS_IE_F1O = 6;
   localparam int CFS_IE_ERRW = 8;
   localparam int CFS_IE_ERRP = 9;
   localparam int CFS_IE_BOFF = 10;
   localparam int CFS_IE_LEC = 11;
   localparam int CFS_IE_ERR = 15;
   localparam int CFS_IE_WUP = 16;
   localparam int CFS_IE_SLP = 17;
   localparam logic [31:0] CFS_IE_MASK = 32'h0003_8f7f;

   // Error status register fields
   localparam int CFS_ES_IFLG = 0;

   // Thresholds
   localparam logic [2:0] CFS_FIFO_DEPTH = 3'h3;
   localparam logic [8:0] CFS_WARN_LVL = 9'h060;
   localparam logic [8:0] CFS_PASS_LVL = 9'h07f;
   localparam logic [8:0] CFS_BOFF_LVL = 9'h0ff;

   // Error inputs from the protocol engine
   typedef struct packed {
      logic [8:0] tx_err_cnt;
      logic [7:0] rx_err_cnt;
      logic [2:0] last_error_code;
      logic lec_update;
   } cfs_err_in_t;

   // Interrupt outputs
   typedef struct packed {
      logic tx_irq;
      logic fifo0_irq;
      logic fifo1_irq;
      logic err_irq;
      logic wakeup_irq;
      logic sleep_irq;
   } cfs_irq_t;

endpackage

// File: hw/cfs_top.sv
`timescale 1ns/1ns
`default_nettype none

module cfs_top
   import cfs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Controller events
   input wire logic fifo1_msg_received,
   input wire logic [2:0] tx_request_complete_flag,
   input wire logic [1:0] fifo0_msg_count,
   input wire logic fifo0_full_flag,
   input wire logic fifo0_overrun_flag,
   input wire cfs_err_in_t err_in,
   input wire logic wakeup_flag,
   input wire logic sleep_ack_irq_flag,
   // Status back to the controller
   output logic fifo1_release_pulse,
   output logic bus_off_flag,
   // Interrupts
   output cfs_irq_t irq
);

   ////////////////////////////////////////////////////////////////////////
   logic [1:0] fifo1_msg_count_q;
   logic fifo1_full_flag_q;
   logic fifo1_overrun_flag_q;
   logic [31:0] interrupt_enable_q;
   logic error_irq_flag_q;
   logic err_warning_flag_q;
   logic err_passive_flag_q;
   logic bus_off_flag_q;
   logic warn_prev_q;
   logic pass_prev_q;
   logic boff_prev_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic release_q;
   logic tx_irq_q;
   logic fifo0_irq_q;
   logic fifo1_irq_q;
   logic err_irq_q;
   logic wakeup_irq_q;
   logic sleep_irq_q;

   logic acc;
   logic wr;
   logic wr_rxf1;
   logic wr_ie;
   logic wr_es;
   logic do_release;
   logic fifo_is_full;
   logic mapped;
   logic warn_rise;
   logic pass_rise;
   logic boff_rise;
   logic lec_new;
   logic err_set;

   assign acc = psel && penable && !pready_q;
   assign wr = acc && pwrite;
   assign wr_rxf1 = wr && (paddr == CFS_OFF_RXF1);
   assign wr_ie = wr && (paddr == CFS_OFF_INTEN);
   assign wr_es = wr && (paddr == CFS_OFF_ERRSTAT);
   assign mapped = (paddr == CFS_OFF_RXF1) || (paddr == CFS_OFF_INTEN) ||
                   (paddr == CFS_OFF_ERRSTAT);
   // Empty FIFO makes the release a no-op
   assign do_release = wr_rxf1 && pwdata[CFS_RXF1_REL] &&
                       (fifo1_msg_count_q != 2'h0);
   assign fifo_is_full = ({1'b0, fifo1_msg_count_q} == CFS_FIFO_DEPTH);

   function automatic logic edge_up(input logic now, input logic prev);
      edge_up = now && !prev;
   endfunction

   // Either counter at or above a level; receive counter is eight bits
   function automatic logic at_level(input logic [8:0] tx_cnt,
                                     input logic [7:0] rx_cnt,
                                     input logic [8:0] lvl);
      at_level = (tx_cnt >= lvl) || ({1'b0, rx_cnt} >= lvl);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // FIFO 1 count; receive into a full FIFO is dropped
   // Limitation: receive and release together while full drops the receive
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo1_msg_count_q <= 2'h0;
      end else begin
         unique case ({fifo1_msg_received && !fifo_is_full, do_release})
            2'b10: fifo1_msg_count_q <= fifo1_msg_count_q + 2'h1;
            2'b01: fifo1_msg_count_q <= fifo1_msg_count_q - 2'h1;
            default: fifo1_msg_count_q <= fifo1_msg_count_q;
         endcase
      end
   end

   // Set wins over a same-cycle write-one clear
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo1_full_flag_q <= 1'b0;
      end else if (fifo1_msg_received && fifo1_msg_count_q == 2'h2 &&
                   !do_release) begin
         fifo1_full_flag_q <= 1'b1;
      end else if (wr_rxf1 && pwdata[CFS_RXF1_FULL]) begin
         fifo1_full_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo1_overrun_flag_q <= 1'b0;
      end else if (fifo1_msg_received && fifo_is_full) begin
         fifo1_overrun_flag_q <= 1'b1;
      end else if (wr_rxf1 && pwdata[CFS_RXF1_OVR]) begin
         fifo1_overrun_flag_q <= 1'b0;
      end
   end

   // Next message only valid after this pulse reaches the mailbox
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         release_q <= 1'b0;
      end else begin
         release_q <= do_release;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt enable register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         interrupt_enable_q <= CFS_RST_INTEN;
      end else if (wr_ie) begin
         interrupt_enable_q <= pwdata & CFS_IE_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Error state from counters
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         err_warning_flag_q <= 1'b0;
      end else begin
         err_warning_flag_q <= at_level(err_in.tx_err_cnt, err_in.rx_err_cnt,
                                        CFS_WARN_LVL);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         err_passive_flag_q <= 1'b0;
      end else begin
         err_passive_flag_q <= at_level(err_in.tx_err_cnt, err_in.rx_err_cnt,
                                        CFS_PASS_LVL);
      end
   end

   // Nine-bit counter: above 255 means the top bit is set
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_off_flag_q <= 1'b0;
      end else begin
         bus_off_flag_q <= (err_in.tx_err_cnt > CFS_BOFF_LVL);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         warn_prev_q <= 1'b0;
      end else begin
         warn_prev_q <= err_warning_flag_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pass_prev_q <= 1'b0;
      end else begin
         pass_prev_q <= err_passive_flag_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         boff_prev_q <= 1'b0;
      end else begin
         boff_prev_q <= bus_off_flag_q;
      end
   end

   // Edges only, so a standing level does not refill a cleared flag
   assign warn_rise = interrupt_enable_q[CFS_IE_ERRW] &&
                      edge_up(err_warning_flag_q, warn_prev_q);
   assign pass_rise = interrupt_enable_q[CFS_IE_ERRP] &&
                      edge_up(err_passive_flag_q, pass_prev_q);
   assign boff_rise = interrupt_enable_q[CFS_IE_BOFF] &&
                      edge_up(bus_off_flag_q, boff_prev_q);
   // Zero code means a clean frame, so it never raises the flag
   assign lec_new = interrupt_enable_q[CFS_IE_LEC] && err_in.lec_update &&
                    (err_in.last_error_code != 3'h0);
   assign err_set = warn_rise || pass_rise || boff_rise || lec_new;

   // Error interrupt flag, cleared by writing one; set wins
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         error_irq_flag_q <= 1'b0;
      end else if (err_set) begin
         error_irq_flag_q <= 1'b1;
      end else if (wr_es && pwdata[CFS_ES_IFLG]) begin
         error_irq_flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt levels, one flop each so outputs come from flops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_irq_q <= 1'b0;
      end else begin
         tx_irq_q <= interrupt_enable_q[CFS_IE_TXME] &&
                     (|tx_request_complete_flag);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo0_irq_q <= 1'b0;
      end else begin
         fifo0_irq_q <= (interrupt_enable_q[CFS_IE_F0P] &&
                         fifo0_msg_count != 2'h0) ||
                        (interrupt_enable_q[CFS_IE_F0F] && fifo0_full_flag) ||
                        (interrupt_enable_q[CFS_IE_F0O] && fifo0_overrun_flag);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo1_irq_q <= 1'b0;
      end else begin
         fifo1_irq_q <= (interrupt_enable_q[CFS_IE_F1P] &&
                         fifo1_msg_count_q != 2'h0) ||
                        (interrupt_enable_q[CFS_IE_F1F] && fifo1_full_flag_q) ||
                        (interrupt_enable_q[CFS_IE_F1O] && fifo1_overrun_flag_q);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         err_irq_q <= 1'b0;
      end else begin
         err_irq_q <= interrupt_enable_q[CFS_IE_ERR] &&
                      error_irq_flag_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wakeup_irq_q <= 1'b0;
      end else begin
         wakeup_irq_q <= interrupt_enable_q[CFS_IE_WUP] &&
                         wakeup_flag;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_irq_q <= 1'b0;
      end else begin
         sleep_irq_q <= interrupt_enable_q[CFS_IE_SLP] &&
                        sleep_ack_irq_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB: one wait state; ready and error ride together
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc && !mapped;
      end
   end

   // Read data is zero outside the answer cycle, so a stale word never leaks
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= 32'h0000_0000;
         if (acc && !pwrite) begin
            unique case (paddr)
               CFS_OFF_RXF1: begin
                  prdata_q[CFS_RXF1_CNT_LO +: 2] <= fifo1_msg_count_q;
                  prdata_q[CFS_RXF1_FULL] <= fifo1_full_flag_q;
                  prdata_q[CFS_RXF1_OVR] <= fifo1_overrun_flag_q;
               end
               CFS_OFF_INTEN: prdata_q <= interrupt_enable_q;
               CFS_OFF_ERRSTAT: begin
                  prdata_q[CFS_ES_IFLG] <= error_irq_flag_q;
                  prdata_q[1] <= err_warning_flag_q;
                  prdata_q[2] <= err_passive_flag_q;
                  prdata_q[3] <= bus_off_flag_q;
               end
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign fifo1_release_pulse = release_q;
   assign bus_off_flag = bus_off_flag_q;
   assign irq = {tx_irq_q, fifo0_irq_q, fifo1_irq_q, err_irq_q,
                 wakeup_irq_q, sleep_irq_q};

endmodule

`default_nettype wire

// File: tb/cfs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cfs_chk
   import cfs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Events and outputs
   input wire logic [2:0] tx_request_complete_flag,
   input wire logic wakeup_flag,
   input wire logic sleep_ack_irq_flag,
   input wire cfs_err_in_t err_in,
   input wire logic fifo1_release_pulse,
   input wire logic bus_off_flag,
   input wire cfs_irq_t irq
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_b);
logic rel;
// Taken release write, whatever the count; the pulse may still be held back
assign rel = psel && penable && !pready && pwrite &&
   paddr == CFS_OFF_RXF1 && pwdata[CFS_RXF1_REL];
////////////////////////////////////////////////////////////////////////
apb_answer_a:
   assert property (psel && penable && !pready |=> pready)
   else $error("no ready after access phase");
ready_pulse_a:
   assert property (pready |=> !pready) else $error("ready held too long");
idle_data_a:
   assert property (!pready |-> prdata == 32'h0 && !pslverr)
   else $error("read data or error outside answer");
slverr_data_a:
   assert property (pslverr |-> prdata == 32'h0)
   else $error("error read not zero");
release_pulse_a:
   assert property (fifo1_release_pulse |-> $past(rel) || $past(rel, 2))
   else $error("release pulse without release write");
bus_off_a:
   assert property (1 |=> bus_off_flag ==
                    ($past(err_in.tx_err_cnt) > CFS_BOFF_LVL))
   else $error("bus off flag wrong");
tx_irq_off_a:
   assert property (tx_request_complete_flag == 3'h0 |=> !irq.tx_irq)
   else $error("transmit irq without source");
wakeup_off_a:
   assert property (!wakeup_flag |=> !irq.wakeup_irq)
   else $error("wakeup irq no source");
sleep_off_a:
   assert property (!sleep_ack_irq_flag |=> !irq.sleep_irq)
   else $error("sleep irq no source");
endmodule
bind cfs_top cfs_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_request_complete_flag(tx_request_complete_flag),
   .wakeup_flag(wakeup_flag), .sleep_ack_irq_flag(sleep_ack_irq_flag),
   .err_in(err_in), .fifo1_release_pulse(fifo1_release_pulse),
   .bus_off_flag(bus_off_flag), .irq(irq));
`default_nettype wire

// File: tb/cfs_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module cfs_top_test
   import cfs_pkg::*;
;
logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, rx, f0full;
logic f0ovr, wup, slp, rel_p, boff, e;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [2:0] txc;
logic [1:0] f0cnt;
cfs_err_in_t err_in;
cfs_irq_t irq;
int n_errors = 0;
int compares = 0;
logic [8:0] cnt_tab [4] = '{9'h05f, 9'h060, 9'h07f, 9'h100};
logic [31:0] st_tab [4] = '{32'h0, 32'h3, 32'h7, 32'hf};
cfs_top DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fifo1_msg_received(rx), .tx_request_complete_flag(txc),
   .fifo0_msg_count(f0cnt), .fifo0_full_flag(f0full),
   .fifo0_overrun_flag(f0ovr), .err_in(err_in), .wakeup_flag(wup),
   .sleep_ack_irq_flag(slp), .fifo1_release_pulse(rel_p),
   .bus_off_flag(boff), .irq(irq));
////////////////////////////////////////////////////////////////////////
task automatic report_and_stop;
   if (n_errors == 0 && compares > 0) $display("Simulation passed");
   else $display("Simulation failed");
   $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   compares++;
   if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
   end
endtask
// Master waits for pready with no assumed latency; bounded against hangs
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
   int n;
   @(posedge sys_clk);
   psel <= 1'b1;
   pwrite <= wr;
   paddr <= a;
   pwdata <= d;
   @(posedge sys_clk);
   penable <= 1'b1;
   n = 0;
   do begin
      @(posedge sys_clk);
      n++;
   end while (pready !== 1'b1 && n < 20);
   if (n >= 20) begin
      n_errors++;
      report_and_stop();
   end
   rd = prdata;
   e = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
   apb(1'b1, a, d);
endtask
task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
   apb(1'b0, a, 32'h0);
   chk(rd, exp);
endtask
task automatic rx_msg;
   @(posedge sys_clk);
   rx <= 1'b1;
   @(posedge sys_clk);
   rx <= 1'b0;
endtask
task automatic lec_try(input logic [31:0] ie, input logic [31:0] exp);
   wr(CFS_OFF_INTEN, ie);
   wr(CFS_OFF_ERRSTAT, 32'h1);
   err_in.last_error_code <= 3'h3;
   err_in.lec_update <= 1'b1;
   @(posedge sys_clk);
   err_in.lec_update <= 1'b0;
   repeat (5) @(posedge sys_clk);
   rdc(CFS_OFF_ERRSTAT, exp);
endtask
task automatic src(input logic [31:0] ie, input logic [31:0] exp);
   wr(CFS_OFF_INTEN, ie);
   repeat (3) @(posedge sys_clk);
   chk({26'h0, irq}, exp);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
   sys_clk = 1'b0;
   forever #10 sys_clk = ~sys_clk;
end
initial begin
   #400000;
   n_errors++;
   report_and_stop();
end
initial begin
   {rst_b, psel, penable, pwrite, rx, f0full, f0ovr, wup, slp} = '0;
   paddr = '0;
   pwdata = '0;
   txc = '0;
   f0cnt = '0;
   err_in = '0;
   repeat (3) @(posedge sys_clk);
   rst_b <= 1'b1;
   rdc(CFS_OFF_RXF1, CFS_RST_RXF1);
   rdc(CFS_OFF_INTEN, CFS_RST_INTEN);
   wr(CFS_OFF_INTEN, 32'hffff_ffff);
   rdc(CFS_OFF_INTEN, CFS_IE_MASK);
   rdc(12'h020, 32'h0);
   chk(e, 1'b1);
   // Fill to full, then one more for overrun
   repeat (3) rx_msg();
   rdc(CFS_OFF_RXF1, 32'h0b);
   chk({26'h0, irq}, 32'h08);
   rx_msg();
   rdc(CFS_OFF_RXF1, 32'h1b);
   wr(CFS_OFF_RXF1, 32'h18);
   rdc(CFS_OFF_RXF1, 32'h03);
   for (int i = 2; i >= 0; i--) begin
      wr(CFS_OFF_RXF1, 32'h20);
      chk(rel_p, 1'b1);
      rdc(CFS_OFF_RXF1, i);
   end
   wr(CFS_OFF_RXF1, 32'h20);
   chk(rel_p, 1'b0);
   rdc(CFS_OFF_RXF1, 32'h0);
   chk({26'h0, irq}, 32'h0);
   // Error thresholds, one step below warning first
   for (int i = 0; i < 4; i++) begin
      wr(CFS_OFF_ERRSTAT, 32'h1);
      err_in.tx_err_cnt <= cnt_tab[i];
      repeat (5) @(posedge sys_clk);
      rdc(CFS_OFF_ERRSTAT, st_tab[i]);
      chk({26'h0, irq}, (i == 0) ? 32'h0 : 32'h4);
   end
   chk(boff, 1'b1);
   lec_try(CFS_IE_MASK, 32'hf);
   lec_try(32'h0003_877f, 32'he);
   err_in.tx_err_cnt <= 9'h0;
   repeat (5) @(posedge sys_clk);
   wr(CFS_OFF_ERRSTAT, 32'h1);
   {wup, slp, txc, f0cnt} <= {1'b1, 1'b1, 3'h4, 2'h1};
   src(CFS_IE_MASK, 32'h33);
   src(32'h0, 32'h0);
   {f0cnt, f0full} <= {2'h0, 1'b1};
   src(32'h4, 32'h10);
   {f0full, f0ovr} <= {1'b0, 1'b1};
   src(32'h8, 32'h10);
   src(32'h4, 32'h0);
   report_and_stop();
end
endmodule
`default_nettype wire
